//--- hw/clock_divider_settings_pkg.sv
// constants and types for the divider settings bank
package clock_divider_settings_pkg;

  // register offsets
  localparam logic [7:0] OUTPUT_HIGHSPEED_DIVIDE_OFS = 8'h19;
  localparam logic [7:0] OUTPUT_ONE_DIVIDE_HIGH_OFS = 8'h1f;
  localparam logic [7:0] OUTPUT_ONE_DIVIDE_MID_OFS = 8'h20;
  localparam logic [7:0] OUTPUT_ONE_DIVIDE_LOW_OFS = 8'h21;
  localparam logic [7:0] OUTPUT_TWO_DIVIDE_HIGH_OFS = 8'h22;
  localparam logic [7:0] OUTPUT_TWO_DIVIDE_MID_OFS = 8'h23;
  localparam logic [7:0] OUTPUT_TWO_DIVIDE_LOW_OFS = 8'h24;
  localparam logic [7:0] FEEDBACK_DIVIDE_HIGH_OFS = 8'h28;

  // field positions
  localparam int HS_CODE_LSB = 5;
  localparam int HS_CODE_MSB = 7;
  localparam int LS_NIBBLE_LSB = 0;
  localparam int LS_NIBBLE_MSB = 3;

  // reset values
  localparam logic [7:0] OUTPUT_HIGHSPEED_DIVIDE_RST = 8'h20;
  localparam logic [7:0] OUTPUT_DIVIDE_HIGH_RST = 8'h00;
  localparam logic [7:0] OUTPUT_DIVIDE_MID_RST = 8'h00;
  localparam logic [7:0] OUTPUT_DIVIDE_LOW_RST = 8'h31;
  localparam logic [7:0] FEEDBACK_DIVIDE_HIGH_RST = 8'hc0;

  // divider arithmetic
  localparam logic [3:0] HS_RATIO_BASE = 4'h4;
  localparam logic [2:0] HS_CODE_NO_SKEW = 3'h0;
  localparam logic [20:0] LS_RATIO_STEP = 21'h000001;

  typedef struct packed {
    logic [3:0] output_highspeed_ratio;
    logic [20:0] output_one_lowspeed_ratio;
    logic [20:0] output_two_lowspeed_ratio;
    logic [3:0] feedback_highspeed_ratio;
    logic [20:0] feedback_lowspeed_ratio;
  } div_ratios_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

//--- hw/clock_divider_settings.sv
// divider chain configuration registers and ratio outputs
`timescale 1ns/1ps

// Overview of operation
// - output high-speed ratio is code plus four
// - output code zero blocks coarse skew changes
// - output one low-speed field from three registers
// - output two low-speed field from three registers
// - feedback high-speed ratio is code plus four
// - feedback low-speed top nibble beside feedback code
// - feedback low-speed ratio is field plus one
// - output high-speed register resets to 0x20
// - feedback high-speed register resets to 0xc0
// - output low byte registers reset to 0x31
module clock_divider_settings
  import clock_divider_settings_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic SKEW_INC,
  input wire logic LATENCY_CHANGE,
  output logic SKEW_STEP,
  input wire logic [15:0] FEEDBACK_LOWSPEED_LOW,
  output div_ratios_t DIV_RATIOS
);

  function automatic logic [3:0] hs_ratio(input logic [2:0] code);
    hs_ratio = HS_RATIO_BASE + {1'b0, code};
  endfunction

  function automatic logic [20:0] ls_ratio(input logic [19:0] field);
    ls_ratio = {1'b0, field} + LS_RATIO_STEP;
  endfunction

  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  logic [2:0] output_highspeed_div_code;
  logic [3:0] output_one_lowspeed_top;
  logic [7:0] output_one_lowspeed_mid;
  logic [7:0] output_one_lowspeed_low;
  logic [19:0] output_one_lowspeed_div;
  logic [3:0] output_two_lowspeed_top;
  logic [7:0] output_two_lowspeed_mid;
  logic [7:0] output_two_lowspeed_low;
  logic [19:0] output_two_lowspeed_div;
  logic [2:0] feedback_highspeed_div_code;
  logic [3:0] feedback_lowspeed_div_top;
  logic [19:0] feedback_lowspeed_div;
  logic hit_out_hs;
  logic hit_one_high;
  logic hit_one_mid;
  logic hit_one_low;
  logic hit_two_high;
  logic hit_two_mid;
  logic hit_two_low;
  logic hit_fb_high;
  logic store_out_hs;
  logic store_one_high;
  logic store_one_mid;
  logic store_one_low;
  logic store_two_high;
  logic store_two_mid;
  logic store_two_low;
  logic store_fb_high;
  logic [7:0] out_hs_word;
  logic [7:0] one_high_word;
  logic [7:0] one_mid_word;
  logic [7:0] one_low_word;
  logic [7:0] two_high_word;
  logic [7:0] two_mid_word;
  logic [7:0] two_low_word;
  logic [7:0] fb_high_word;
  logic [7:0] next_rdata;
  logic [3:0] next_output_highspeed_ratio;
  logic [20:0] next_output_one_lowspeed_ratio;
  logic [20:0] next_output_two_lowspeed_ratio;
  logic [3:0] next_feedback_highspeed_ratio;
  logic [20:0] next_feedback_lowspeed_ratio;
  logic [7:0] wd;
  logic wr;
  logic rd;
  logic skew_request;
  logic skew_allowed;

  assign wd = REG_REQ.wdata;
  assign wr = REG_REQ.write;
  assign rd = REG_REQ.read;

  // one select per mapped register
  assign hit_out_hs = reg_hit(REG_REQ.addr, OUTPUT_HIGHSPEED_DIVIDE_OFS);
  assign hit_one_high = reg_hit(REG_REQ.addr, OUTPUT_ONE_DIVIDE_HIGH_OFS);
  assign hit_one_mid = reg_hit(REG_REQ.addr, OUTPUT_ONE_DIVIDE_MID_OFS);
  assign hit_one_low = reg_hit(REG_REQ.addr, OUTPUT_ONE_DIVIDE_LOW_OFS);
  assign hit_two_high = reg_hit(REG_REQ.addr, OUTPUT_TWO_DIVIDE_HIGH_OFS);
  assign hit_two_mid = reg_hit(REG_REQ.addr, OUTPUT_TWO_DIVIDE_MID_OFS);
  assign hit_two_low = reg_hit(REG_REQ.addr, OUTPUT_TWO_DIVIDE_LOW_OFS);
  assign hit_fb_high = reg_hit(REG_REQ.addr, FEEDBACK_DIVIDE_HIGH_OFS);

  // unmapped writes match no strobe
  assign store_out_hs = wr && hit_out_hs;
  assign store_one_high = wr && hit_one_high;
  assign store_one_mid = wr && hit_one_mid;
  assign store_one_low = wr && hit_one_low;
  assign store_two_high = wr && hit_two_high;
  assign store_two_mid = wr && hit_two_mid;
  assign store_two_low = wr && hit_two_low;
  assign store_fb_high = wr && hit_fb_high;

  assign output_one_lowspeed_div = {output_one_lowspeed_top, output_one_lowspeed_mid,
                                    output_one_lowspeed_low};
  assign output_two_lowspeed_div = {output_two_lowspeed_top, output_two_lowspeed_mid,
                                    output_two_lowspeed_low};
  assign feedback_lowspeed_div = {feedback_lowspeed_div_top, FEEDBACK_LOWSPEED_LOW};

  assign skew_request = SKEW_INC || LATENCY_CHANGE;
  assign skew_allowed = (output_highspeed_div_code != HS_CODE_NO_SKEW);

  assign next_output_highspeed_ratio = hs_ratio(output_highspeed_div_code);
  assign next_output_one_lowspeed_ratio = ls_ratio(output_one_lowspeed_div);
  assign next_output_two_lowspeed_ratio = ls_ratio(output_two_lowspeed_div);
  assign next_feedback_highspeed_ratio = hs_ratio(feedback_highspeed_div_code);
  assign next_feedback_lowspeed_ratio = ls_ratio(feedback_lowspeed_div);

  // output high-speed code register
  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_highspeed_div_code <=
        OUTPUT_HIGHSPEED_DIVIDE_RST[HS_CODE_MSB:HS_CODE_LSB];
    end else if (store_out_hs) begin
      output_highspeed_div_code <= wd[HS_CODE_MSB:HS_CODE_LSB];
    end
  end

  // output one low-speed field slices
  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_one_lowspeed_top <= OUTPUT_DIVIDE_HIGH_RST[LS_NIBBLE_MSB:LS_NIBBLE_LSB];
    end else if (store_one_high) begin
      output_one_lowspeed_top <= wd[LS_NIBBLE_MSB:LS_NIBBLE_LSB];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_one_lowspeed_mid <= OUTPUT_DIVIDE_MID_RST;
    end else if (store_one_mid) begin
      output_one_lowspeed_mid <= wd;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_one_lowspeed_low <= OUTPUT_DIVIDE_LOW_RST;
    end else if (store_one_low) begin
      output_one_lowspeed_low <= wd;
    end
  end

  // output two low-speed field slices
  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_two_lowspeed_top <= OUTPUT_DIVIDE_HIGH_RST[LS_NIBBLE_MSB:LS_NIBBLE_LSB];
    end else if (store_two_high) begin
      output_two_lowspeed_top <= wd[LS_NIBBLE_MSB:LS_NIBBLE_LSB];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_two_lowspeed_mid <= OUTPUT_DIVIDE_MID_RST;
    end else if (store_two_mid) begin
      output_two_lowspeed_mid <= wd;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      output_two_lowspeed_low <= OUTPUT_DIVIDE_LOW_RST;
    end else if (store_two_low) begin
      output_two_lowspeed_low <= wd;
    end
  end

  // feedback high-speed code
  always_ff @(posedge CLK) begin
    if (SRST) begin
      feedback_highspeed_div_code <=
        FEEDBACK_DIVIDE_HIGH_RST[HS_CODE_MSB:HS_CODE_LSB];
    end else if (store_fb_high) begin
      feedback_highspeed_div_code <= wd[HS_CODE_MSB:HS_CODE_LSB];
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      feedback_lowspeed_div_top <=
        FEEDBACK_DIVIDE_HIGH_RST[LS_NIBBLE_MSB:LS_NIBBLE_LSB];
    end else if (store_fb_high) begin
      feedback_lowspeed_div_top <= wd[LS_NIBBLE_MSB:LS_NIBBLE_LSB];
    end
  end

  // read-back words
  always_comb begin
    out_hs_word = 8'h00;
    one_high_word = 8'h00;
    two_high_word = 8'h00;
    fb_high_word = 8'h00;
    out_hs_word[HS_CODE_MSB:HS_CODE_LSB] = output_highspeed_div_code;
    one_high_word[LS_NIBBLE_MSB:LS_NIBBLE_LSB] = output_one_lowspeed_top;
    two_high_word[LS_NIBBLE_MSB:LS_NIBBLE_LSB] = output_two_lowspeed_top;
    fb_high_word[HS_CODE_MSB:HS_CODE_LSB] = feedback_highspeed_div_code;
    fb_high_word[LS_NIBBLE_MSB:LS_NIBBLE_LSB] = feedback_lowspeed_div_top;
  end

  assign one_mid_word = output_one_lowspeed_mid;
  assign one_low_word = output_one_lowspeed_low;
  assign two_mid_word = output_two_lowspeed_mid;
  assign two_low_word = output_two_lowspeed_low;

  // read mux, unmapped reads give zero
  always_comb begin
    next_rdata = 8'h00;
    if (hit_out_hs) begin
      next_rdata = out_hs_word;
    end else if (hit_one_high) begin
      next_rdata = one_high_word;
    end else if (hit_one_mid) begin
      next_rdata = one_mid_word;
    end else if (hit_one_low) begin
      next_rdata = one_low_word;
    end else if (hit_two_high) begin
      next_rdata = two_high_word;
    end else if (hit_two_mid) begin
      next_rdata = two_mid_word;
    end else if (hit_two_low) begin
      next_rdata = two_low_word;
    end else if (hit_fb_high) begin
      next_rdata = fb_high_word;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= rd;
    end
  end

  // read data held until the next read
  always_ff @(posedge CLK) begin
    if (SRST) begin
      REG_RDATA <= 8'h00;
    end else if (rd) begin
      REG_RDATA <= next_rdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      SKEW_STEP <= 1'b0;
    end else begin
      SKEW_STEP <= skew_request && skew_allowed;
    end
  end

  // ratios read zero during reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      DIV_RATIOS <= '0;
    end else begin
      DIV_RATIOS.output_highspeed_ratio <= next_output_highspeed_ratio;
      DIV_RATIOS.output_one_lowspeed_ratio <= next_output_one_lowspeed_ratio;
      DIV_RATIOS.output_two_lowspeed_ratio <= next_output_two_lowspeed_ratio;
      DIV_RATIOS.feedback_highspeed_ratio <= next_feedback_highspeed_ratio;
      DIV_RATIOS.feedback_lowspeed_ratio <= next_feedback_lowspeed_ratio;
    end
  end

endmodule // clock_divider_settings

//--- test/clock_divider_settings_checker.sv
// port assertions for the divider settings bank
`timescale 1ns/1ps
module clock_divider_settings_checker
  import clock_divider_settings_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire reg_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic SKEW_INC,
  input wire logic LATENCY_CHANGE,
  input wire logic SKEW_STEP,
  input wire logic [15:0] FEEDBACK_LOWSPEED_LOW,
  input wire div_ratios_t DIV_RATIOS
);
  logic [20:0] one_f;
  logic [20:0] two_f;
  logic [20:0] fb_f;
  assign one_f = DIV_RATIOS.output_one_lowspeed_ratio - 21'h1;
  assign two_f = DIV_RATIOS.output_two_lowspeed_ratio - 21'h1;
  assign fb_f = DIV_RATIOS.feedback_lowspeed_ratio - 21'h1;
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  sequence s_wr(logic [7:0] a);
    REG_REQ.write && REG_REQ.addr == a;
  endsequence
  sequence s_hs_zero;
    REG_REQ.write && REG_REQ.addr == 8'h19 && REG_REQ.wdata[7:5] == 3'h0;
  endsequence
  AST_OUT_HS: assert property (s_wr(8'h19) |=> ##1
    DIV_RATIOS.output_highspeed_ratio == {1'b0, $past(REG_REQ.wdata[7:5], 2)} + 4'h4)
    else $error("output high-speed ratio wrong");
  AST_SKEW_BLOCK: assert property (s_hs_zero
    ##1 (SKEW_INC || LATENCY_CHANGE) |=> !SKEW_STEP) else $error("skew step not blocked");
  AST_ONE_NIB: assert property (s_wr(8'h1f) |=> ##1
    one_f[19:16] == $past(REG_REQ.wdata[3:0], 2)) else $error("output one nibble wrong");
  AST_TWO_MID: assert property (s_wr(8'h23) |=> ##1
    two_f[15:8] == $past(REG_REQ.wdata, 2)) else $error("output two mid byte wrong");
  AST_FB_HS: assert property (s_wr(8'h28) |=> ##1
    DIV_RATIOS.feedback_highspeed_ratio == {1'b0, $past(REG_REQ.wdata[7:5], 2)} + 4'h4)
    else $error("feedback high-speed ratio wrong");
  AST_FB_NIB: assert property (s_wr(8'h28) |=> ##1
    fb_f[19:16] == $past(REG_REQ.wdata[3:0], 2)) else $error("feedback nibble wrong");
  AST_FB_LOW: assert property (!SRST |=>
    fb_f[15:0] == $past(FEEDBACK_LOWSPEED_LOW)) else $error("feedback low bits wrong");
  AST_RESET_VALS: assert property ($fell(SRST) |=>
    DIV_RATIOS.output_highspeed_ratio == 4'h5 && DIV_RATIOS.feedback_highspeed_ratio == 4'ha
    && one_f == 21'h31 && two_f == 21'h31) else $error("ratios after reset wrong");
  AST_RSV_READ: assert property (REG_REQ.read && REG_REQ.addr == 8'h19 |=>
    REG_RVALID && REG_RDATA[4:0] == 5'h0) else $error("reserved bits not zero");
endmodule // clock_divider_settings_checker
bind clock_divider_settings clock_divider_settings_checker clock_divider_settings_checker_inst (
  .CLK(CLK), .SRST(SRST), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
  .SKEW_INC(SKEW_INC), .LATENCY_CHANGE(LATENCY_CHANGE), .SKEW_STEP(SKEW_STEP),
  .FEEDBACK_LOWSPEED_LOW(FEEDBACK_LOWSPEED_LOW), .DIV_RATIOS(DIV_RATIOS));

//--- test/test_clock_divider_settings.sv
// self-checking bench for the divider settings bank
`timescale 1ns/1ps
module test_clock_divider_settings
  import clock_divider_settings_pkg::*;
;
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  reg_req_t REG_REQ = '0;
  logic SKEW_INC = 1'b0;
  logic LATENCY_CHANGE = 1'b0;
  logic [15:0] FEEDBACK_LOWSPEED_LOW = 16'h0001;
  logic [7:0] REG_RDATA;
  logic REG_RVALID;
  logic SKEW_STEP;
  div_ratios_t DIV_RATIOS;
  div_ratios_t e;
  int err_count = 0;
  int checks = 0;
  int ci = 0;
  logic rv_e;
  logic sk_e;
  logic [7:0] rd_e;
  logic [15:0] r;
  logic [15:0] w;
  logic [15:0] seed = 16'h3dc5;
  logic [7:0] adr [9] = '{8'h19, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h28, 8'h25};
  logic [7:0] msk [9] = '{8'he0, 8'h0f, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hef, 8'h00};
  logic [7:0] rst [9] = '{8'h20, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00, 8'h31, 8'hc0, 8'h00};
  logic [7:0] m [9];
  always #50 CLK = ~CLK;
  clock_divider_settings clock_divider_settings_inst (.CLK(CLK), .SRST(SRST),
    .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .SKEW_INC(SKEW_INC),
    .LATENCY_CHANGE(LATENCY_CHANGE), .SKEW_STEP(SKEW_STEP),
    .FEEDBACK_LOWSPEED_LOW(FEEDBACK_LOWSPEED_LOW), .DIV_RATIOS(DIV_RATIOS));
  function automatic logic [15:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed;
  endfunction
  task automatic chk(string n, logic [70:0] x, logic [70:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic end_of_test();
    if (err_count == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #80000;
    err_count++;
    end_of_test();
  end
  initial begin
    rd_e = 8'h00;
    for (int j = 0; j < 9; j++) m[j] = rst[j];
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    for (int i = 0; i < 600; i++) begin
      @(posedge CLK);
      if (SRST) begin
        for (int j = 0; j < 9; j++) m[j] = rst[j];
        e = '0;
        rv_e = 1'b0;
        sk_e = 1'b0;
        rd_e = 8'h00;
      end else begin
        e = {4'(m[0][7:5]) + 4'h4, {1'b0, m[1][3:0], m[2], m[3]} + 21'h1,
          {1'b0, m[4][3:0], m[5], m[6]} + 21'h1, 4'(m[7][7:5]) + 4'h4,
          {1'b0, m[7][3:0], FEEDBACK_LOWSPEED_LOW} + 21'h1};
        sk_e = (SKEW_INC || LATENCY_CHANGE) && m[0][7:5] != 3'h0;
        rv_e = REG_REQ.read;
        if (REG_REQ.read) rd_e = m[ci];
        if (REG_REQ.write) m[ci] = (m[ci] & ~msk[ci]) | (REG_REQ.wdata & msk[ci]);
      end
      r = rnd();
      w = rnd();
      ci = int'(r[15:8]) % 9;
      if (i == 300) SRST <= 1'b1;
      if (i == 302) SRST <= 1'b0;
      REG_REQ.addr <= adr[ci];
      REG_REQ.read <= r[0] && !(i inside {300, 301});
      REG_REQ.write <= r[1] && !(i inside {300, 301});
      REG_REQ.wdata <= (ci == 3 || ci == 6) ? (w[7:0] | 8'h01) : w[7:0];
      SKEW_INC <= r[2];
      LATENCY_CHANGE <= r[3] & r[4];
      FEEDBACK_LOWSPEED_LOW <= {w[15:8], r[7:0]} | 16'h0001;
      #1;
      chk("DIV_RATIOS", e, DIV_RATIOS);
      chk("REG_RVALID", 71'(rv_e), 71'(REG_RVALID));
      chk("REG_RDATA", 71'(rd_e), 71'(REG_RDATA));
      chk("SKEW_STEP", 71'(sk_e), 71'(SKEW_STEP));
    end
    end_of_test();
  end
endmodule // test_clock_divider_settings
